/* File: dot_sub_pkg.sv */
// Purpose: Shared constants and types for the subtracting dot-product unit.
// Assumes: 32-bit AHB-Lite register bus, byte addresses in haddr[7:0].
// Notes:   Accumulator pair p, word w sits at 0x40 + 16*p + 4*w.
`default_nettype none

package dot_sub_pkg;

    // --------------------
    // Register map
    // --------------------
    localparam logic [7:0] ADDR_OP1_LO = 8'h00;
    localparam logic [7:0] ADDR_OP1_HI = 8'h04;
    localparam logic [7:0] ADDR_OP2_LO = 8'h08;
    localparam logic [7:0] ADDR_OP2_HI = 8'h0c;
    localparam logic [7:0] ADDR_INSTR = 8'h10;
    localparam logic [7:0] ADDR_CTRL_WORD = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;
    localparam logic [7:0] ADDR_CONFIG = 8'h20;
    localparam logic [1:0] ACC_BASE_TOP = 2'h1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0001;
    localparam int CONFIG_ENABLE_BIT = 0;

    // --------------------
    // Interrupt status layout
    // --------------------
    localparam int IRQ_W = 6;
    localparam int IRQ_RSVD_BIT = 4;
    localparam int IRQ_DIS_BIT = 5;
    localparam int FLAG_BASE = 16;

    // --------------------
    // Instruction encoding
    // --------------------
    localparam logic [5:0] MAJOR_OPC = 6'h1f;
    localparam logic [5:0] FUNC_GROUP = 6'h30;
    localparam logic [5:0] FUNC_QUAD = 6'h34;
    localparam logic [4:0] SUB_PW = 5'h0d;
    localparam logic [4:0] SUB_SW = 5'h0d;
    localparam logic [4:0] SUB_X = 5'h19;
    localparam logic [4:0] SUB_XS = 5'h1b;

    // --------------------
    // Fixed-point limits
    // --------------------
    localparam logic [15:0] HALF_NEG_ONE = 16'h8000;
    localparam logic [31:0] WORD_NEG_ONE = 32'h8000_0000;
    localparam logic [31:0] Q31_MAX = 32'h7fff_ffff;
    localparam logic [63:0] Q63_MAX = 64'h7fff_ffff_ffff_ffff;
    localparam logic [63:0] Q63_MIN = 64'h8000_0000_0000_0000;
    localparam logic [63:0] Q31_MAX_64 = 64'h0000_0000_7fff_ffff;
    localparam logic [63:0] Q31_MIN_64 = 64'hffff_ffff_8000_0000;

    typedef enum logic [4:0]
    {
        OP_NONE = 5'b00001,
        OP_PW = 5'b00010,
        OP_SW = 5'b00100,
        OP_X = 5'b01000,
        OP_XS = 5'b10000
    } op_e;

endpackage

`default_nettype wire

/* File: dot_sub_unit.sv */
// Purpose: Subtracting fractional dot-product datapath with AHB-Lite access.
// Assumes: Software loads operands, then writes an instruction word.
// Notes:   Every transfer takes one wait state; results land one cycle
//          after the instruction word is written.
// Overview of operation
// - Any saturation sets control word bit 16 plus selected pair.
// - Two-bit selector picks one of four pairs; pair 0 is original.
// - Paired-word: multiply upper halves and lower halves as Q31.
// - Paired-word: 129-bit subtract, clamp when bits 64, 63 differ.
// - Single-word: Q31 product shifted; both -1.0 gives Q63 max, flag.
// - Single-word: 65-bit minuend from low words of pair, minus product.
// - Single-word: bits 64, 63 differ clamps to Q63 min or max, flag.
// - 64-bit results split into sign-extended halves of the pair.
// - Cross: upper times lower halfword, lower times upper halfword.
// - Halfword multiply shifts left; both -1.0 gives Q31 max, flag.
// - Cross: sum extended products, subtract, no final saturation.
// - Saturating cross: clamp result to Q31 range.
// - Saturating cross: flag on product or final saturation.
// - Decode by major opcode, zero bits, function and sub-op codes.
// - No data-dependent exceptions; only reserved or disabled traps.
// - Paired-word products are sign-extended to 128 bits and summed.
`default_nettype none

module dot_sub_unit
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Interrupt
    output logic irq
);
    import dot_sub_pkg::*;

    // ------------------------------------------------------------
    // Arithmetic helpers
    // ------------------------------------------------------------
    // Result carries the saturation indication in its top bit.
    function automatic logic [64:0] word_fraction_multiply(
        input logic [31:0] a,
        input logic [31:0] b
    );
        logic signed [63:0] p;
        p = $signed(a) * $signed(b);
        if (a == WORD_NEG_ONE && b == WORD_NEG_ONE)
        begin
            return {1'b1, Q63_MAX};
        end
        return {1'b0, p[62:0], 1'b0};
    endfunction

    function automatic logic [32:0] half_fraction_multiply(
        input logic [15:0] a,
        input logic [15:0] b
    );
        logic signed [31:0] p;
        p = $signed(a) * $signed(b);
        if (a == HALF_NEG_ONE && b == HALF_NEG_ONE)
        begin
            return {1'b1, Q31_MAX};
        end
        return {1'b0, p[30:0], 1'b0};
    endfunction

    // Spreads a 64-bit result over both registers of a pair.
    function automatic logic [127:0] split_result(input logic [63:0] r);
        return {{32{r[63]}}, r[63:32], {32{r[31]}}, r[31:0]};
    endfunction

    // ------------------------------------------------------------
    // Bus slave state
    // ------------------------------------------------------------
    logic dp_valid_q;
    logic dp_write_q;
    logic [7:0] dp_addr_q;
    logic wr_fire;
    logic rd_fire;
    logic addr_take;

    logic [63:0] op1_q;
    logic [63:0] op2_q;
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic [31:0] config_q;
    logic [IRQ_W-1:0] stat_q;
    logic [IRQ_W-1:0] stat_d;
    logic [IRQ_W-1:0] mask_q;
    logic [63:0] hi_q [4];
    logic [63:0] lo_q [4];

    op_e op_q;
    logic [1:0] pick_q;
    logic rsvd_ev;
    logic dis_ev;
    op_e op_dec;

    assign addr_take = hsel & htrans[1] & hready;
    assign wr_fire = dp_valid_q & ~hreadyout & dp_write_q;
    assign rd_fire = dp_valid_q & ~hreadyout & ~dp_write_q;

    // One wait state lets a read see any write or result of the
    // previous transfer without a forwarding path.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_valid_q <= 1'b0;
            dp_write_q <= 1'b0;
            dp_addr_q <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hresp <= 1'b0;
            if (dp_valid_q)
            begin
                dp_valid_q <= 1'b0;
                hreadyout <= 1'b1;
            end
            else if (addr_take)
            begin
                dp_valid_q <= 1'b1;
                dp_write_q <= hwrite;
                dp_addr_q <= {haddr[7:2], 2'b00};
                hreadyout <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Instruction decode
    // ------------------------------------------------------------
    always_comb
    begin
        op_dec = OP_NONE;
        if (hwdata[31:26] == MAJOR_OPC && hwdata[15:13] == 3'h0)
        begin
            if (hwdata[5:0] == FUNC_QUAD && hwdata[10:6] == SUB_PW)
            begin
                op_dec = OP_PW;
            end
            else if (hwdata[5:0] == FUNC_GROUP)
            begin
                case (hwdata[10:6])
                    SUB_SW: op_dec = OP_SW;
                    SUB_X: op_dec = OP_X;
                    SUB_XS: op_dec = OP_XS;
                    default: op_dec = OP_NONE;
                endcase
            end
        end
    end

    // Only the encoding and the enable can trap; data never does.
    assign dis_ev = wr_fire && dp_addr_q == ADDR_INSTR
        && !config_q[CONFIG_ENABLE_BIT];
    assign rsvd_ev = wr_fire && dp_addr_q == ADDR_INSTR
        && config_q[CONFIG_ENABLE_BIT] && op_dec == OP_NONE;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            op_q <= OP_NONE;
            pick_q <= 2'h0;
        end
        else if (wr_fire && dp_addr_q == ADDR_INSTR
            && config_q[CONFIG_ENABLE_BIT])
        begin
            op_q <= op_dec;
            pick_q <= hwdata[12:11];
        end
        else
        begin
            op_q <= OP_NONE;
        end
    end

    // ------------------------------------------------------------
    // Datapath
    // ------------------------------------------------------------
    logic [63:0] acc_hi;
    logic [63:0] acc_lo;
    logic [64:0] prod_b;
    logic [64:0] prod_a;
    logic [32:0] half_b;
    logic [32:0] half_a;
    logic [127:0] dot_wide;
    logic [128:0] diff_wide;
    logic [63:0] dot_narrow;
    logic [64:0] diff_narrow;
    logic [63:0] res64;
    logic [63:0] res_hi;
    logic [63:0] res_lo;
    logic sat;

    assign acc_hi = hi_q[pick_q];
    assign acc_lo = lo_q[pick_q];

    always_comb
    begin
        prod_b = 65'h0;
        prod_a = 65'h0;
        half_b = 33'h0;
        half_a = 33'h0;
        dot_wide = 128'h0;
        diff_wide = 129'h0;
        dot_narrow = 64'h0;
        diff_narrow = 65'h0;
        res64 = 64'h0;
        res_hi = acc_hi;
        res_lo = acc_lo;
        sat = 1'b0;
        case (op_q)
            OP_PW:
            begin
                prod_b = word_fraction_multiply(op1_q[63:32],
                    op2_q[63:32]);
                prod_a = word_fraction_multiply(op1_q[31:0],
                    op2_q[31:0]);
                dot_wide = {{64{prod_b[63]}}, prod_b[63:0]}
                    + {{64{prod_a[63]}}, prod_a[63:0]};
                diff_wide = {acc_hi[63], acc_hi, acc_lo}
                    - {dot_wide[127], dot_wide};
                sat = prod_b[64] | prod_a[64];
                if (diff_wide[64] != diff_wide[63])
                begin
                    sat = 1'b1;
                    diff_wide[127:0] = diff_wide[64]
                        ? {{64{1'b1}}, Q63_MIN} : {64'h0, Q63_MAX};
                end
                res_hi = diff_wide[127:64];
                res_lo = diff_wide[63:0];
            end
            OP_SW:
            begin
                prod_a = word_fraction_multiply(op1_q[31:0],
                    op2_q[31:0]);
                diff_narrow = {acc_hi[31], acc_hi[31:0], acc_lo[31:0]}
                    - {prod_a[63], prod_a[63:0]};
                sat = prod_a[64];
                res64 = diff_narrow[63:0];
                if (diff_narrow[64] != diff_narrow[63])
                begin
                    sat = 1'b1;
                    res64 = diff_narrow[64] ? Q63_MIN : Q63_MAX;
                end
                {res_hi, res_lo} = split_result(res64);
            end
            OP_X, OP_XS:
            begin
                half_b = half_fraction_multiply(op1_q[31:16],
                    op2_q[15:0]);
                half_a = half_fraction_multiply(op1_q[15:0],
                    op2_q[31:16]);
                dot_narrow = {{32{half_b[31]}}, half_b[31:0]}
                    + {{32{half_a[31]}}, half_a[31:0]};
                res64 = {acc_hi[31:0], acc_lo[31:0]}
                    - dot_narrow;
                sat = half_b[32] | half_a[32];
                if (op_q == OP_XS)
                begin
                    if (!res64[63] && res64[62:31] != 32'h0)
                    begin
                        res64 = Q31_MAX_64;
                        sat = 1'b1;
                    end
                    else if (res64[63] && res64[62:31] != 32'hffff_ffff)
                    begin
                        res64 = Q31_MIN_64;
                        sat = 1'b1;
                    end
                end
                {res_hi, res_lo} = split_result(res64);
            end
            default:
            begin
                sat = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Accumulator pairs
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < 4; i++)
            begin
                hi_q[i] <= 64'h0;
                lo_q[i] <= 64'h0;
            end
        end
        else if (op_q != OP_NONE)
        begin
            hi_q[pick_q] <= res_hi;
            lo_q[pick_q] <= res_lo;
        end
        else if (wr_fire && dp_addr_q[7:6] == ACC_BASE_TOP)
        begin
            case (dp_addr_q[3:2])
                2'h0: hi_q[dp_addr_q[5:4]][31:0] <= hwdata;
                2'h1: hi_q[dp_addr_q[5:4]][63:32] <= hwdata;
                2'h2: lo_q[dp_addr_q[5:4]][31:0] <= hwdata;
                default: lo_q[dp_addr_q[5:4]][63:32] <= hwdata;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Operand, config and control word registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            op1_q <= 64'h0;
            op2_q <= 64'h0;
            config_q <= CONFIG_RESET;
            mask_q <= '0;
        end
        else if (wr_fire)
        begin
            case (dp_addr_q)
                ADDR_OP1_LO: op1_q[31:0] <= hwdata;
                ADDR_OP1_HI: op1_q[63:32] <= hwdata;
                ADDR_OP2_LO: op2_q[31:0] <= hwdata;
                ADDR_OP2_HI: op2_q[63:32] <= hwdata;
                ADDR_CONFIG: config_q <= hwdata;
                ADDR_IRQ_MASK: mask_q <= hwdata[IRQ_W-1:0];
                default: config_q <= config_q;
            endcase
        end
    end

    // A saturating operation only ever ORs a one in, so a software
    // write in the same cycle cannot hide it.
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (wr_fire && dp_addr_q == ADDR_CTRL_WORD)
        begin
            ctrl_d = hwdata;
        end
        if (sat)
        begin
            ctrl_d[FLAG_BASE + int'(pick_q)] = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_q <= CTRL_RESET;
        end
        else
        begin
            ctrl_q <= ctrl_d;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, cleared by reading it
    // ------------------------------------------------------------
    always_comb
    begin
        stat_d = stat_q;
        if (rd_fire && dp_addr_q == ADDR_IRQ_STAT)
        begin
            stat_d = '0;
        end
        if (sat)
        begin
            stat_d[pick_q] = 1'b1;
        end
        if (rsvd_ev)
        begin
            stat_d[IRQ_RSVD_BIT] = 1'b1;
        end
        if (dis_ev)
        begin
            stat_d[IRQ_DIS_BIT] = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            stat_q <= '0;
            irq <= 1'b0;
        end
        else
        begin
            stat_q <= stat_d;
            irq <= |(stat_d & mask_q);
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0;
        end
        else if (rd_fire)
        begin
            if (dp_addr_q[7:6] == ACC_BASE_TOP)
            begin
                case (dp_addr_q[3:2])
                    2'h0: hrdata <= hi_q[dp_addr_q[5:4]][31:0];
                    2'h1: hrdata <= hi_q[dp_addr_q[5:4]][63:32];
                    2'h2: hrdata <= lo_q[dp_addr_q[5:4]][31:0];
                    default: hrdata <= lo_q[dp_addr_q[5:4]][63:32];
                endcase
            end
            else
            begin
                case (dp_addr_q)
                    ADDR_OP1_LO: hrdata <= op1_q[31:0];
                    ADDR_OP1_HI: hrdata <= op1_q[63:32];
                    ADDR_OP2_LO: hrdata <= op2_q[31:0];
                    ADDR_OP2_HI: hrdata <= op2_q[63:32];
                    ADDR_CTRL_WORD: hrdata <= ctrl_q;
                    ADDR_IRQ_STAT: hrdata <= {26'h0, stat_q};
                    ADDR_IRQ_MASK: hrdata <= {26'h0, mask_q};
                    ADDR_CONFIG: hrdata <= config_q;
                    default: hrdata <= 32'h0;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

/* File: dot_sub_unit_assertions.sv */
// Purpose: Port-level checks on the subtracting dot-product unit.
// Assumes: Single slave, hready tied to hreadyout.
// Notes:   Shadow flags track what software has seen on the bus.
`default_nettype none

module dot_sub_unit_checker
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Interrupt
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    import dot_sub_pkg::*;

    logic taken, rd_done, wr_done, dp_q, dp_wr_q, ctrl_wr_q, stat_clean_q;
    logic [7:0] dp_addr_q;
    logic [IRQ_W-1:0] mask_q;
    logic [3:0] flags_q;

    assign taken = hsel && htrans[1] && hready;
    assign rd_done = dp_q && !dp_wr_q && hready;
    assign wr_done = dp_q && dp_wr_q && hready;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            dp_q <= 1'b0;
        else if (taken)
            dp_q <= 1'b1;
        else if (hready)
            dp_q <= 1'b0;
    end

    always_ff @(posedge hclk)
    begin
        if (taken)
        begin
            dp_wr_q <= hwrite;
            dp_addr_q <= haddr[7:0];
        end
    end

    // A status read empties the status, so only instructions refill it.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mask_q <= '0;
            flags_q <= 4'h0;
            ctrl_wr_q <= 1'b0;
            stat_clean_q <= 1'b1;
        end
        else
        begin
            if (wr_done && dp_addr_q == ADDR_IRQ_MASK)
                mask_q <= hwdata[IRQ_W-1:0];
            if (wr_done && dp_addr_q == ADDR_CTRL_WORD)
                {ctrl_wr_q, flags_q} <= {1'b1, hwdata[FLAG_BASE +: 4]};
            else if (rd_done && dp_addr_q == ADDR_CTRL_WORD)
                flags_q <= hrdata[FLAG_BASE +: 4];
            if (wr_done && dp_addr_q == ADDR_INSTR)
                stat_clean_q <= 1'b0;
            else if (rd_done && dp_addr_q == ADDR_IRQ_STAT)
                stat_clean_q <= 1'b1;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    AST_ONE_WAIT: assert property (taken |=> !hreadyout ##1 hreadyout)
        else $error("transfer wait state count wrong");
    AST_RESP_OKAY: assert property (hresp == 1'b0)
        else $error("error response seen");
    AST_RDATA_HOLD: assert property ($changed(hrdata) |-> rd_done)
        else $error("read data moved outside a read");
    AST_IRQ_MASKED: assert property
        ((mask_q == '0 && $past(mask_q) == '0) |-> !irq)
        else $error("interrupt raised while fully masked");
    AST_FLAGS_STICKY: assert property (rd_done &&
        dp_addr_q == ADDR_CTRL_WORD |->
        (hrdata[FLAG_BASE +: 4] & flags_q) == flags_q)
        else $error("saturation flag lost");
    AST_CTRL_ONLY_FLAGS: assert property (rd_done &&
        dp_addr_q == ADDR_CTRL_WORD && !ctrl_wr_q |->
        (hrdata & 32'hfff0_ffff) == 32'h0000_0000)
        else $error("control bit outside flag field set");
    AST_EMPTY_READ: assert property (rd_done && (dp_addr_q == ADDR_INSTR
        || dp_addr_q[7:2] inside {[6'h09:6'h0f]}
        || dp_addr_q[7:6] > ACC_BASE_TOP) |-> hrdata == 32'h0000_0000)
        else $error("unmapped or instruction read not zero");
    AST_STAT_CLEARED: assert property (rd_done && stat_clean_q &&
        dp_addr_q == ADDR_IRQ_STAT |-> hrdata == 32'h0000_0000)
        else $error("status not cleared by read");

    COV_FLAG_READ: cover property (rd_done && hrdata[FLAG_BASE + 3]);
    COV_IRQ_RISE: cover property ($rose(irq));
    COV_EXEC: cover property (wr_done && dp_addr_q == ADDR_INSTR);
endmodule

bind dot_sub_unit dot_sub_unit_checker u_chk
(
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .irq
);

`default_nettype wire

/* File: host_bus_model.sv */
// Purpose: AHB-Lite master standing in for the host pipeline.
// Assumes: One slave, so hready is that slave's hreadyout.
// Notes:   Released address and data lines carry inverted values so stale data never match.
`default_nettype none

module host_bus_model
(
    // Clock
    input wire logic hclk,
    // Request lines
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    // Answer lines
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
    end

    // Holds each phase until hready is seen high; no cycle count assumed.
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        haddr <= ~{24'h00_0000, a};
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        hwdata <= ~wd;
    endtask
endmodule

`default_nettype wire

/* File: testbench.sv */
// Purpose: Self-checking bench for the subtracting dot-product unit.
// Assumes: Accumulator values are written as {low64, high64}.
// Notes:   Each operation test uses its own pair where it can.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import dot_sub_pkg::*;

    logic hclk, hresetn, hsel, hwrite, hreadyout, irq;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    int num_errors = 0;
    int checks = 0;

    dot_sub_unit dut
    (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .irq
    );

    host_bus_model host
    (
        .hclk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata
    );

    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // --------------------
    // Shared tasks
    // --------------------
    task automatic tally_and_finish;
        if (num_errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        host.xfer(1'b1, a, d, x);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        host.xfer(1'b0, a, 32'h0000_0000, x);
        chk(x, exp);
    endtask

    task automatic irq_is(input logic e);
        @(negedge hclk);
        chk({31'h0, irq}, {31'h0, e});
    endtask

    task automatic acc_set(input logic [1:0] p, input logic [127:0] v);
        for (int w = 0; w < 4; w++)
            wr({ACC_BASE_TOP, p, w[1:0], 2'b00}, v[32*w +: 32]);
    endtask

    task automatic acc_chk(input logic [1:0] p, input logic [127:0] v);
        for (int w = 0; w < 4; w++)
            rc({ACC_BASE_TOP, p, w[1:0], 2'b00}, v[32*w +: 32]);
    endtask

    // Loads pair and operands, then issues the instruction.
    task automatic op(input logic [1:0] p, input logic [127:0] v,
                      input logic [63:0] a, input logic [63:0] b,
                      input logic [4:0] s, input logic [5:0] f);
        acc_set(p, v);
        wr(ADDR_OP1_LO, a[31:0]);
        wr(ADDR_OP1_HI, a[63:32]);
        wr(ADDR_OP2_LO, b[31:0]);
        wr(ADDR_OP2_HI, b[63:32]);
        wr(ADDR_INSTR, {MAJOR_OPC, 10'h0, 3'h0, p, s, f});
    endtask

    // --------------------
    // Scenarios
    // --------------------
    task automatic t_reset;
        rc(ADDR_CTRL_WORD, CTRL_RESET);
        rc(ADDR_CONFIG, CONFIG_RESET);
        rc(ADDR_IRQ_STAT, 32'h0000_0000);
        rc(ADDR_IRQ_MASK, 32'h0000_0000);
        rc(ADDR_INSTR, 32'h0000_0000);
        rc(8'h3c, 32'h0000_0000);
    endtask

    task automatic t_single;
        op(2'h1, '0, 64'h8000_0000, 64'h8000_0000, SUB_SW, FUNC_GROUP);
        acc_chk(2'h1, 128'h0000000000000001ffffffff80000000);
        op(2'h2, 128'h9abcdef0ffffffff123456787fffffff,
           64'hffff_ffff, 64'h1, SUB_SW, FUNC_GROUP);
        acc_chk(2'h2, 128'hffffffffffffffff000000007fffffff);
    endtask

    task automatic t_irq;
        irq_is(1'b0);
        wr(ADDR_IRQ_MASK, 32'h0000_003f);
        rc(ADDR_CTRL_WORD, 32'h0006_0000);
        irq_is(1'b1);
        rc(ADDR_IRQ_STAT, 32'h0000_0006);
        rc(ADDR_IRQ_STAT, 32'h0000_0000);
        irq_is(1'b0);
    endtask

    task automatic t_paired;
        op(2'h0, '0, 64'h8000_0000_8000_0000, 64'h8000_0000_8000_0000,
           SUB_PW, FUNC_QUAD);
        acc_chk(2'h0, 128'h8000000000000000ffffffffffffffff);
        op(2'h0, '0, 64'h4000_0000_0000_0003, 64'h0000_0002_4000_0000,
           SUB_PW, FUNC_QUAD);
        acc_chk(2'h0, 128'hfffffffd80000000ffffffffffffffff);
    endtask

    task automatic t_cross;
        op(2'h0, 128'h00000000000000100000000000000000,
           64'h0002_0003, 64'h0005_0007, SUB_X, FUNC_GROUP);
        acc_chk(2'h0, 128'hffffffffffffffd6ffffffffffffffff);
        rc(ADDR_CTRL_WORD, 32'h0007_0000);
    endtask

    task automatic t_cross_sat;
        op(2'h3, '0, 64'h8000_8000, 64'h8000_8000, SUB_XS, FUNC_GROUP);
        acc_chk(2'h3, 128'hffffffff80000000ffffffffffffffff);
        rc(ADDR_CTRL_WORD, 32'h000f_0000);
        op(2'h3, 128'h000000007ffffffe0000000000000000,
           64'h0001_0000, 64'h0000_ffff, SUB_XS, FUNC_GROUP);
        acc_chk(2'h3, 128'h000000007fffffff0000000000000000);
    endtask

    task automatic t_trap;
        logic [31:0] bad [3];
        bad[0] = {6'h1e, 10'h0, 3'h0, 2'h0, SUB_X, FUNC_GROUP};
        bad[1] = {MAJOR_OPC, 10'h0, 3'h1, 2'h0, SUB_X, FUNC_GROUP};
        bad[2] = {MAJOR_OPC, 10'h0, 3'h0, 2'h0, 5'h05, FUNC_GROUP};
        irq_is(1'b1);
        rc(ADDR_IRQ_STAT, 32'h0000_0009);
        for (int i = 0; i < 3; i++)
        begin
            wr(ADDR_INSTR, bad[i]);
            rc(ADDR_IRQ_STAT, 32'h1 << IRQ_RSVD_BIT);
        end
        wr(ADDR_CONFIG, 32'h0000_0000);
        wr(ADDR_INSTR, {MAJOR_OPC, 10'h0, 3'h0, 2'h3, SUB_X, FUNC_GROUP});
        rc(ADDR_IRQ_STAT, 32'h1 << IRQ_DIS_BIT);
        acc_chk(2'h3, 128'h000000007fffffff0000000000000000);
        wr(ADDR_CONFIG, CONFIG_RESET);
    endtask

    // --------------------
    // Main sequence and watchdog
    // --------------------
    initial
    begin
        hresetn = 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_single();
        t_irq();
        t_paired();
        t_cross();
        t_cross_sat();
        t_trap();
        tally_and_finish();
    end

    // Some 120 transfers of four cycles; ten times over.
    initial
    begin
        repeat (5000) @(posedge hclk);
        num_errors++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
